// *** hdl/pfc_params.svh ***
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH

// register byte offsets
`define PFC_ADR_CTRL 8'h00
`define PFC_ADR_FCB_ADDR 8'h04
`define PFC_ADR_FCB_DATA 8'h08
`define PFC_ADR_STATUS 8'h0C
`define PFC_ADR_FORM 8'h10

// control register fields
`define PFC_CTRL_MODE63 0
`define PFC_CTRL_TRUNC 1
`define PFC_CTRL_BOFCH_LSB 4
`define PFC_CTRL_SKIP_LSB 8
`define PFC_CTRL_PLEN_LSB 16
// page length 66 lines, bottom channel 12
`define PFC_CTRL_RESET 32'h0042_00C0

// status register fields
`define PFC_STAT_ONLINE 0
`define PFC_STAT_BUSY 1
`define PFC_STAT_FEEDING 2
`define PFC_STAT_LOADED 3
`define PFC_STAT_CNT_LSB 8
`define PFC_STAT_POS_LSB 16

// line and codes
`define PFC_LINE_WIDTH 8'h84
`define PFC_SPACE_BIT 4
`define PFC_CODE_DC1 8'h11
`define PFC_CODE_DC3 8'h13
`define PFC_CODE_CR 8'h0D
`define PFC_CODE_LF 8'h0A
`define PFC_CODE_VT 8'h0B
`define PFC_CODE_FF 8'h0C
`define PFC_CODE_SPACE 8'h20

// timing
`define PFC_CLK_MHZ 200
`define PFC_ACK_MIN_NS 2500
`define PFC_ACK_MAX_NS 5500
`define PFC_ACK_CYC ((`PFC_ACK_MIN_NS * `PFC_CLK_MHZ + 999) / 1000)
`define PFC_ACK_MAX_CYC ((`PFC_ACK_MAX_NS * `PFC_CLK_MHZ) / 1000)

`endif

// *** hdl/pfc_pkg.sv ***
package pfc_pkg;
    typedef enum logic [2:0] {
        ST_OFFLINE,
        ST_IDLE,
        ST_HOLD,
        ST_PAD,
        ST_PRINT,
        ST_PWAIT,
        ST_FWAIT
    } pfc_state_t;
endpackage

// *** hdl/pfc_form_scan.sv ***
`timescale 1ns/1ps
`include "pfc_params.svh"
module pfc_form_scan (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [11:0] wr_data,
    input wire logic clear,
    input wire logic [7:0] page_len,
    input wire logic [3:0] bof_chan,
    input wire logic [7:0] skip_lines,
    output logic loaded,
    output logic [7:0] tof_line,
    output logic [7:0] bof_line
);
    // one entry per form line, bit k-1 marks channel k
    logic [11:0] fcb_mem [256];
    logic [7:0] idx, tof_pos, bof_pos, next_idx, next_tof_pos, next_bof_pos;
    logic tof_hit, bof_hit, next_tof_hit, next_bof_hit, next_loaded;
    logic [7:0] next_tof_line, next_bof_line;
    logic [11:0] entry;

    assign entry = fcb_mem[idx];

    // free-running scan: results refresh once per page, so a reload shows up within two pages
    always_comb begin
        next_idx = idx + 8'h01;
        next_tof_pos = tof_pos;
        next_bof_pos = bof_pos;
        next_tof_hit = tof_hit;
        next_bof_hit = bof_hit;
        next_tof_line = tof_line;
        next_bof_line = bof_line;
        next_loaded = loaded;
        if (!tof_hit && entry[0]) begin
            next_tof_hit = 1'b1;
            next_tof_pos = idx;
        end
        if (!bof_hit && bof_chan >= 4'h2 && bof_chan <= 4'hC && entry[bof_chan - 4'h1]) begin
            next_bof_hit = 1'b1;
            next_bof_pos = idx;
        end
        if (idx + 8'h01 >= page_len) begin
            next_idx = 8'h00;
            // results latch before the hit flags rearm, else every scan reports a miss
            next_tof_line = (loaded && next_tof_hit) ? next_tof_pos : 8'h00;
            next_bof_line = (loaded && next_bof_hit) ? next_bof_pos
                          : page_len - 8'h01 - skip_lines;
            next_tof_hit = 1'b0;
            next_bof_hit = 1'b0;
        end
        if (wr_en) begin
            next_loaded = 1'b1;
        end
        if (clear) begin
            next_loaded = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            idx <= 8'h00;
            tof_pos <= 8'h00;
            bof_pos <= 8'h00;
            tof_hit <= 1'b0;
            bof_hit <= 1'b0;
            tof_line <= 8'h00;
            bof_line <= 8'h41;
            loaded <= 1'b0;
        end else begin
            idx <= next_idx;
            tof_pos <= next_tof_pos;
            bof_pos <= next_bof_pos;
            tof_hit <= next_tof_hit;
            bof_hit <= next_bof_hit;
            tof_line <= next_tof_line;
            bof_line <= next_bof_line;
            loaded <= next_loaded;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            fcb_mem[wr_addr] <= wr_data;
        end
    end

    property p_unloaded_tof;
        @(posedge clk_sys) disable iff (!rst_b)
        (!loaded && !$past(loaded) && idx == 8'h00 && $past(idx) != 8'h00) |-> tof_line == 8'h00;
    endproperty
    a_unloaded_tof: assert property (p_unloaded_tof) else $error("tof not first line");
endmodule

// *** hdl/pfc_feed_ctrl.sv ***
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pfc_params.svh"
// Summary of operation
// - a paper-instruction byte is a space command only with data bit 5 set
// - 15-line mode: lines from bits 4..1, bits 6..8 ignored
// - 63-line mode: lines from bits 7,6 high and 4..1 low, bit 8 ignored
// - a space command prints the buffered line first, then feeds
// - a short line ended by a space command is padded with spaces up to full width
// - a space command with an empty line only feeds
// - with truncation enabled a feed stops at the top-of-form line
// - go online on start/stop press or a strobed 0x11
// - going online raises select, drops busy and pulses acknowledge
// - print on CR, LF, FF, VT, DC3, forms command, or full buffer
// - characters go to print positions in arrival order
// - one line before the feed ends, acknowledge and drop busy; a feed cut short at the top-of-form line acknowledges only once it stops
// - go offline on start/stop, input prime, 0x13, or fault
// - loaded forms data: top of form is first channel 1 line
// - no forms data or no channel 1: top of form is line 0
// - loaded forms data: bottom of form is first bottom-channel line
// - otherwise bottom of form is last line less skipped lines
// - data is latched on the strobe rising edge
// - busy is high whenever the device cannot take data
// - acknowledge is one pulse of 2.5 to 5.5 us
// - input prime clears buffers and goes offline after the current job
module pfc_feed_ctrl (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] host_data,
    input wire logic host_strobe_b,
    input wire logic paper_instr,
    input wire logic input_prime,
    input wire logic start_stop,
    input wire logic fault,
    output logic busy,
    output logic ack_b,
    output logic select,
    output logic print_start,
    output logic [7:0] print_len,
    input wire logic [7:0] print_addr,
    output logic [7:0] print_data,
    input wire logic print_done,
    output logic feed_req,
    input wire logic line_step
);
    function automatic logic [31:0] pfc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            pfc_merge[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
        end
    endfunction

    // pin synchronisers: data, strobe, paper instruction, prime, start/stop, fault
    logic [12:0] sync1, sync2;
    logic strobe_d, ss_d;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 13'h1100;
            sync2 <= 13'h1100;
            strobe_d <= 1'b1;
            ss_d <= 1'b0;
        end else begin
            sync1 <= {host_strobe_b, fault, start_stop, input_prime, paper_instr, host_data};
            sync2 <= sync1;
            strobe_d <= sync2[12];
            ss_d <= sync2[10];
        end
    end
    logic [7:0] rx_byte;
    logic paper_s, prime_s, fault_s, strobe_rise, ss_rise;
    assign rx_byte = sync2[7:0];
    assign paper_s = sync2[8];
    assign prime_s = sync2[9];
    assign fault_s = sync2[11];
    assign strobe_rise = sync2[12] && !strobe_d;
    assign ss_rise = sync2[10] && !ss_d;

    // wishbone register group
    logic [31:0] ctrl, next_ctrl, next_dat;
    logic [7:0] fcb_addr, next_fcb_addr;
    logic next_wb_ack, fcb_we, wb_wr;
    logic [31:0] addr_merged;
    logic mode63, trunc_en, fcb_loaded, fcb_clear;
    logic [7:0] page_len, tof_line, bof_line;
    pfc_pkg::pfc_state_t state, next_state;
    logic feeding;
    logic [7:0] char_cnt, line_pos;

    assign mode63 = ctrl[`PFC_CTRL_MODE63];
    assign trunc_en = ctrl[`PFC_CTRL_TRUNC];
    assign page_len = ctrl[`PFC_CTRL_PLEN_LSB +: 8];
    assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

    always_comb begin
        addr_merged = pfc_merge({24'h00_0000, fcb_addr}, wb_dat_i, wb_sel_i);
        next_wb_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat = 32'h0000_0000;
        next_ctrl = ctrl;
        next_fcb_addr = fcb_addr;
        fcb_we = 1'b0;
        unique case (wb_adr_i)
            `PFC_ADR_CTRL: next_dat = ctrl;
            `PFC_ADR_FCB_ADDR: next_dat = {24'h00_0000, fcb_addr};
            `PFC_ADR_STATUS: begin
                next_dat[`PFC_STAT_ONLINE] = select;
                next_dat[`PFC_STAT_BUSY] = busy;
                next_dat[`PFC_STAT_FEEDING] = feeding;
                next_dat[`PFC_STAT_LOADED] = fcb_loaded;
                next_dat[`PFC_STAT_CNT_LSB +: 8] = char_cnt;
                next_dat[`PFC_STAT_POS_LSB +: 8] = line_pos;
            end
            `PFC_ADR_FORM: next_dat = {16'h0000, bof_line, tof_line};
            default: next_dat = 32'h0000_0000;
        endcase
        if (wb_wr) begin
            if (wb_adr_i == `PFC_ADR_CTRL) begin
                next_ctrl = pfc_merge(ctrl, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == `PFC_ADR_FCB_ADDR) begin
                next_fcb_addr = addr_merged[7:0];
            end
            if (wb_adr_i == `PFC_ADR_FCB_DATA) begin
                // auto-increment lets software stream a whole form without re-addressing
                fcb_we = 1'b1;
                next_fcb_addr = fcb_addr + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl <= `PFC_CTRL_RESET;
            fcb_addr <= 8'h00;
        end else begin
            wb_ack_o <= next_wb_ack;
            wb_dat_o <= next_dat;
            ctrl <= next_ctrl;
            fcb_addr <= next_fcb_addr;
        end
    end

    pfc_form_scan u_scan (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr_en(fcb_we),
        .wr_addr(fcb_addr),
        .wr_data(wb_dat_i[11:0]),
        .clear(fcb_clear),
        .page_len(page_len),
        .bof_chan(ctrl[`PFC_CTRL_BOFCH_LSB +: 4]),
        .skip_lines(ctrl[`PFC_CTRL_SKIP_LSB +: 8]),
        .loaded(fcb_loaded),
        .tof_line(tof_line),
        .bof_line(bof_line)
    );

    // line buffer, print engine and feed engine
    logic [7:0] line_buf [132];
    logic [7:0] pend_lines, next_lines, feed_rem, next_rem, next_cnt, next_pos, next_plen;
    logic pend_ff, next_ff, pend_off, next_off, trunc_now, next_trunc, next_feeding;
    logic [10:0] ack_cnt, next_ack;
    logic buf_we;
    logic [7:0] buf_wd;

    always_comb begin
        next_state = state;
        next_cnt = char_cnt;
        next_lines = pend_lines;
        next_ff = pend_ff;
        next_off = pend_off;
        next_ack = (ack_cnt == 11'h000) ? 11'h000 : ack_cnt - 11'h001;
        next_feeding = feeding;
        next_rem = feed_rem;
        next_pos = line_pos;
        next_trunc = trunc_now;
        next_plen = print_len;
        buf_we = 1'b0;
        buf_wd = rx_byte;
        print_start = 1'b0;
        fcb_clear = 1'b0;
        if (feeding && line_step) begin
            next_pos = (line_pos + 8'h01 >= page_len) ? 8'h00 : line_pos + 8'h01;
            next_rem = feed_rem - 8'h01;
            if (feed_rem == 8'h01 || (trunc_now && next_pos == tof_line)) begin
                next_feeding = 1'b0;
                next_rem = 8'h00;
            end
        end
        unique case (state)
            pfc_pkg::ST_OFFLINE: begin
                if (prime_s) begin
                    next_cnt = 8'h00;
                    fcb_clear = 1'b1;
                end else if (!fault_s && (ss_rise ||
                             (strobe_rise && rx_byte == `PFC_CODE_DC1))) begin
                    next_state = pfc_pkg::ST_IDLE;
                    next_ack = 11'(`PFC_ACK_CYC);
                end
            end
            pfc_pkg::ST_IDLE: begin
                // offline requests are honoured only here, so a running job always completes
                if (ss_rise || prime_s || fault_s) begin
                    next_state = pfc_pkg::ST_OFFLINE;
                    if (prime_s) begin
                        next_cnt = 8'h00;
                        fcb_clear = 1'b1;
                    end
                end else if (strobe_rise) begin
                    next_ff = 1'b0;
                    next_off = 1'b0;
                    next_lines = 8'h00;
                    next_state = pfc_pkg::ST_PRINT;
                    if (paper_s) begin
                        if (rx_byte[`PFC_SPACE_BIT]) begin
                            next_lines = mode63 ? {2'b00, rx_byte[6:5], rx_byte[3:0]}
                                                : {4'h0, rx_byte[3:0]};
                            next_state = pfc_pkg::ST_PAD;
                        end
                    end else if (rx_byte == `PFC_CODE_DC3) begin
                        next_off = 1'b1;
                    end else if (rx_byte == `PFC_CODE_LF || rx_byte == `PFC_CODE_VT) begin
                        next_lines = 8'h01;
                    end else if (rx_byte == `PFC_CODE_FF) begin
                        next_ff = 1'b1;
                        next_lines = page_len;
                    end else if (rx_byte != `PFC_CODE_CR) begin
                        buf_we = 1'b1;
                        next_cnt = char_cnt + 8'h01;
                        if (char_cnt + 8'h01 != `PFC_LINE_WIDTH) begin
                            next_state = pfc_pkg::ST_HOLD;
                        end
                    end
                end
            end
            pfc_pkg::ST_HOLD: begin
                next_state = pfc_pkg::ST_IDLE;
                next_ack = 11'(`PFC_ACK_CYC);
            end
            pfc_pkg::ST_PAD: begin
                if (char_cnt == 8'h00 || char_cnt == `PFC_LINE_WIDTH) begin
                    next_state = pfc_pkg::ST_PRINT;
                end else begin
                    buf_we = 1'b1;
                    buf_wd = `PFC_CODE_SPACE;
                    next_cnt = char_cnt + 8'h01;
                end
            end
            pfc_pkg::ST_PRINT: begin
                // a new line waits here until the overlapped feed of the last one is done
                if (!feeding) begin
                    if (char_cnt == 8'h00) begin
                        next_feeding = pend_lines != 8'h00;
                        next_rem = pend_lines;
                        next_trunc = trunc_en || pend_ff;
                        next_state = pfc_pkg::ST_FWAIT;
                    end else begin
                        print_start = 1'b1;
                        next_plen = char_cnt;
                        next_state = pfc_pkg::ST_PWAIT;
                    end
                end
            end
            pfc_pkg::ST_PWAIT: begin
                if (print_done) begin
                    next_cnt = 8'h00;
                    next_feeding = pend_lines != 8'h00;
                    next_rem = pend_lines;
                    next_trunc = trunc_en || pend_ff;
                    next_state = pfc_pkg::ST_FWAIT;
                end
            end
            pfc_pkg::ST_FWAIT: begin
                if (!feeding || feed_rem == 8'h01) begin
                    if (pend_off) begin
                        next_state = pfc_pkg::ST_OFFLINE;
                    end else begin
                        next_state = pfc_pkg::ST_IDLE;
                        next_ack = 11'(`PFC_ACK_CYC);
                    end
                end
            end
            default: next_state = pfc_pkg::ST_OFFLINE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= pfc_pkg::ST_OFFLINE;
            char_cnt <= 8'h00;
            pend_lines <= 8'h00;
            pend_ff <= 1'b0;
            pend_off <= 1'b0;
            ack_cnt <= 11'h000;
            feeding <= 1'b0;
            feed_rem <= 8'h00;
            line_pos <= 8'h00;
            trunc_now <= 1'b0;
            print_len <= 8'h00;
        end else begin
            state <= next_state;
            char_cnt <= next_cnt;
            pend_lines <= next_lines;
            pend_ff <= next_ff;
            pend_off <= next_off;
            ack_cnt <= next_ack;
            feeding <= next_feeding;
            feed_rem <= next_rem;
            line_pos <= next_pos;
            trunc_now <= next_trunc;
            print_len <= next_plen;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (buf_we) begin
            line_buf[char_cnt] <= buf_wd;
        end
        print_data <= line_buf[print_addr];
    end

    assign ack_b = ack_cnt == 11'h000;
    assign select = state != pfc_pkg::ST_OFFLINE;
    assign busy = state != pfc_pkg::ST_IDLE;
    assign feed_req = feeding;

    // acknowledge pulse length watcher
    logic [11:0] low_len;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            low_len <= 12'h000;
        end else begin
            low_len <= ack_b ? 12'h000 : low_len + 12'h001;
        end
    end

    property p_ack_width;
        @(posedge clk_sys) disable iff (!rst_b)
        $rose(ack_b) |-> (low_len >= `PFC_ACK_CYC && low_len <= `PFC_ACK_MAX_CYC);
    endproperty
    a_ack_width: assert property (p_ack_width) else $error("ack width out of range");

    property p_online;
        @(posedge clk_sys) disable iff (!rst_b)
        (state == pfc_pkg::ST_OFFLINE && !prime_s && !fault_s && strobe_rise &&
         rx_byte == `PFC_CODE_DC1) |=> (select && !busy && !ack_b);
    endproperty
    a_online: assert property (p_online) else $error("dc1 did not bring online");

    property p_space15;
        @(posedge clk_sys) disable iff (!rst_b)
        (state == pfc_pkg::ST_IDLE && !ss_rise && !prime_s && !fault_s && strobe_rise &&
         paper_s && rx_byte[4] && !mode63) |=> pend_lines == {4'h0, $past(rx_byte[3:0])};
    endproperty
    a_space15: assert property (p_space15) else $error("15-line count wrong");

    property p_space63;
        @(posedge clk_sys) disable iff (!rst_b)
        (state == pfc_pkg::ST_IDLE && !ss_rise && !prime_s && !fault_s && strobe_rise &&
         paper_s && rx_byte[4] && mode63) |=>
        pend_lines == {2'b00, $past(rx_byte[6:5]), $past(rx_byte[3:0])} &&
        state == pfc_pkg::ST_PAD;
    endproperty
    a_space63: assert property (p_space63) else $error("63-line count wrong");

    property p_busy_offline;
        @(posedge clk_sys) disable iff (!rst_b)
        (!select || feeding && state == pfc_pkg::ST_PRINT) |-> busy;
    endproperty
    a_busy_offline: assert property (p_busy_offline) else $error("busy low while unable");

    property p_pad;
        @(posedge clk_sys) disable iff (!rst_b)
        (state == pfc_pkg::ST_PAD && char_cnt != 8'h00 && char_cnt != `PFC_LINE_WIDTH) |->
        buf_we && buf_wd == `PFC_CODE_SPACE ##1 char_cnt == $past(char_cnt) + 8'h01;
    endproperty
    a_pad: assert property (p_pad) else $error("pad not a space");

    property p_no_print;
        @(posedge clk_sys) disable iff (!rst_b)
        (state == pfc_pkg::ST_PRINT && char_cnt == 8'h00) |-> !print_start;
    endproperty
    a_no_print: assert property (p_no_print) else $error("empty line printed");

    property p_trunc;
        @(posedge clk_sys) disable iff (!rst_b)
        (feeding && line_step && trunc_now && next_pos == tof_line) |=> !feeding;
    endproperty
    a_trunc: assert property (p_trunc) else $error("feed passed top of form");

    property p_overlap;
        @(posedge clk_sys) disable iff (!rst_b)
        (state == pfc_pkg::ST_FWAIT && feeding && feed_rem == 8'h01 && !pend_off) |=>
        (!busy && !ack_b && feeding);
    endproperty
    a_overlap: assert property (p_overlap) else $error("no overlap before last line");

    property p_dc3;
        @(posedge clk_sys) disable iff (!rst_b)
        (state == pfc_pkg::ST_IDLE && !ss_rise && !prime_s && !fault_s && strobe_rise &&
         !paper_s && rx_byte == `PFC_CODE_DC3 && char_cnt == 8'h00 && !feeding) |=>
        pend_off ##[1:4] !select;
    endproperty
    a_dc3: assert property (p_dc3) else $error("dc3 not taken");
endmodule

// *** tb/pfc_host_model.sv ***
`timescale 1ns/1ps
module pfc_host_model (
    input wire logic clk_sys,
    input wire logic busy,
    input wire logic ack_b,
    output logic [7:0] host_data,
    output logic host_strobe_b,
    output logic paper_instr
);
    initial begin
        host_data = 8'h00;
        host_strobe_b = 1'b1;
        paper_instr = 1'b0;
    end
    // offline the port stays busy, so only the wake-up code skips that wait
    task automatic send(input logic [7:0] b, input logic pi, input logic wack, output logic ok);
        int n;
        n = 0;
        while (((busy !== 1'b0 && b != 8'h11) || ack_b !== 1'b1) && n < 9000) begin
            @(posedge clk_sys);
            n++;
        end
        host_data <= b;
        paper_instr <= pi;
        repeat (4) @(posedge clk_sys);
        host_strobe_b <= 1'b0;
        repeat (4) @(posedge clk_sys);
        host_strobe_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // released lines show the inverse, never a stale copy
        host_data <= ~b;
        paper_instr <= ~pi;
        while (wack && ack_b !== 1'b0 && n < 9000) begin
            @(posedge clk_sys);
            n++;
        end
        ok = n < 9000;
    endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic clk_sys = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00, print_addr = 8'h00, c0, print_len, print_data, host_data;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
    logic [3:0] wb_sel_i = 4'hF;
    logic [1:0] ph = 2'h0;
    logic [31:0] exp_w;
    logic [7:0] exp_b;
    logic prime = 0, ss = 0, flt = 0;
    logic print_done = 0, line_step = 0, busy, ack_b, select, print_start, feed_req;
    logic host_strobe_b, paper_instr, ok;
    int err_total = 0, checks_done = 0, seed = 67, steps = 0, cyc_n = 0, w, r, k;
    logic [31:0] rd_q[$];
    logic [7:0] len_q[$], chr_q[$];
    always #2.5 clk_sys = ~clk_sys;
    pfc_feed_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_data(host_data),
        .host_strobe_b(host_strobe_b), .paper_instr(paper_instr), .input_prime(prime),
        .start_stop(ss), .fault(flt), .busy(busy), .ack_b(ack_b), .select(select),
        .print_start(print_start), .print_len(print_len), .print_addr(print_addr),
        .print_data(print_data), .print_done(print_done), .feed_req(feed_req),
        .line_step(line_step));
    pfc_host_model host (.clk_sys(clk_sys), .busy(busy), .ack_b(ack_b), .host_data(host_data),
        .host_strobe_b(host_strobe_b), .paper_instr(paper_instr));
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_sys) if (++cyc_n > 8000) begin
        err_total++;
        close_out();
    end
    always @(posedge clk_sys) begin
        if (wb_ack_o === 1'b1 && !wb_we_i) begin
            exp_w = rd_q.pop_front();
            `CHK("rd", exp_w, wb_dat_o)
        end
        if (line_step && feed_req === 1'b1) steps++;
        ph <= ph + 2'h1;
        line_step <= feed_req === 1'b1 && ph == 2'h0;
    end
    // mechanism: reads two print positions, then reports the line printed
    always @(posedge clk_sys) if (print_start === 1'b1) begin
        `CHK("start", 1'b1, len_q.size() > 0)
        repeat (2) @(posedge clk_sys);
        exp_b = len_q.pop_front();
        `CHK("len", exp_b, print_len)
        print_addr <= 8'h00;
        repeat (2) @(posedge clk_sys);
        exp_b = chr_q.pop_front();
        `CHK("pos1", exp_b, print_data)
        print_addr <= 8'h83;
        repeat (2) @(posedge clk_sys);
        `CHK("pad", 8'h20, print_data)
        print_done <= 1'b1;
        @(posedge clk_sys) print_done <= 1'b0;
    end
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        if (!we) rd_q.push_back(d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1 && ++n < 50);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic hs(input logic [7:0] b, input logic pi, input logic wack);
        host.send(b, pi, wack, ok);
        `CHK("hs", 1'b1, ok)
    endtask
    task automatic space(input logic [7:0] b, input int n);
        steps = 0;
        hs(b, 1'b1, 1'b1);
        `CHK("overlap", 1'b1, feed_req)
        for (k = 0; k < 200 && feed_req === 1'b1; k++) @(posedge clk_sys);
        `CHK("lines", n, steps)
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        `CHK("busy", 1'b1, busy)
        `CHK("sel", 1'b0, select)
        wb(1'b0, 8'h00, 32'h0042_00C0);
        wb(1'b0, 8'h40, 32'h0000_0000);
        wb(1'b0, 8'h10, 32'h0000_4100);
        wb(1'b1, 8'h04, 32'h0000_0005);
        wb(1'b1, 8'h08, 32'h0000_0001);
        wb(1'b1, 8'h08, 32'h0000_0800);
        // the scan refreshes once per page, so let two pages pass
        repeat (140) @(posedge clk_sys);
        wb(1'b0, 8'h10, 32'h0000_0605);
        hs(8'h11, 1'b0, 1'b1);
        `CHK("online", 1'b1, select)
        `CHK("ready", 1'b0, busy)
        w = 1;
        while (w < 2000) begin
            @(posedge clk_sys);
            if (ack_b !== 1'b0) break;
            w++;
        end
        `CHK("ack_w", 32'h0000_01F4, w)
        r = $random(seed);
        c0 = {4'h3, r[3:0]};
        chr_q.push_back(c0);
        len_q.push_back(8'h84);
        hs(c0, 1'b0, 1'b1);
        hs({4'h4, r[7:4]}, 1'b0, 1'b1);
        space({r[10:8], 5'h13}, 3);
        wb(1'b1, 8'h00, 32'h0042_00C1);
        space({r[11], 7'h51}, 33);
        hs(8'h13, 1'b0, 1'b0);
        for (k = 0; k < 200 && select === 1'b1; k++) @(posedge clk_sys);
        `CHK("offline", 1'b0, select)
        ss <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHK("sw_on", 1'b1, select)
        ss <= 1'b0;
        flt <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHK("fault_off", 1'b0, select)
        flt <= 1'b0;
        ss <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHK("sw_on2", 1'b1, select)
        ss <= 1'b0;
        prime <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHK("prime_off", 1'b0, select)
        repeat (140) @(posedge clk_sys);
        wb(1'b0, 8'h10, 32'h0000_4100);
        prime <= 1'b0;
        close_out();
    end
endmodule
